// file: verilog/ser_pkg.sv
// Shared constants for the status event reporting block
package ser_pkg;

   // =====================================================================
   // Widths
   // =====================================================================
   localparam int unsigned REG_W_REGULATION_SUMMARY_BIT = 16;
   localparam int unsigned REG_W_STD  = 8;
   localparam int unsigned RD_W       = 16;
   localparam int unsigned ERR_KIND_W = 4;

   // =====================================================================
   // Regulation fault event bit positions
   // =====================================================================
   localparam int unsigned QB_VOLT_UNREG = 0;
   localparam int unsigned QB_CURR_UNREG = 1;
   localparam int unsigned QB_OVER_TEMP  = 4;
   localparam int unsigned QB_OVP_TRIP   = 9;
   localparam int unsigned QB_OCP_TRIP   = 10;

   // Bits that can ever be set; all others read as zero
   localparam logic [REG_W_REGULATION_SUMMARY_BIT-1:0] REGULATION_SUMMARY_BIT_USED_MASK = 16'h0613;

   // =====================================================================
   // Command event flag bit positions
   // =====================================================================
   localparam int unsigned SB_OPERATION_DONE = 0;
   localparam int unsigned SB_QUERY_FAULT    = 2;
   localparam int unsigned SB_DEVICE_FAULT   = 3;
   localparam int unsigned SB_EXECUTION      = 4;
   localparam int unsigned SB_SYNTAX         = 5;
   localparam int unsigned SB_POWER_CYCLE    = 7;

   localparam logic [REG_W_STD-1:0] STD_USED_MASK = 8'hBD;

   // =====================================================================
   // Status byte summary bit positions
   // =====================================================================
   localparam int unsigned STB_REGULATION_SUM = 3;
   localparam int unsigned STB_EVENT_SUM      = 5;
   localparam int unsigned STB_W              = 8;

   // =====================================================================
   // Reset values
   // =====================================================================
   localparam logic [REG_W_REGULATION_SUMMARY_BIT-1:0] REGULATION_SUMMARY_BIT_RESET = 16'h0000;
   localparam logic [REG_W_STD-1:0]  STD_RESET  = 8'h00;
   localparam logic [RD_W-1:0]       RD_RESET   = 16'h0000;
   localparam logic [STB_W-1:0]      STB_RESET  = 8'h00;

   // Source of a register read answer
   typedef enum logic [2:0] {
      SER_RD_NONE,
      SER_RD_REGULATION_SUMMARY_BIT_EVT,
      SER_RD_STD_EVT,
      SER_RD_REGULATION_SUMMARY_BIT_EN,
      SER_RD_STD_EN
   } ser_rd_src_t;

endpackage

// file: verilog/ser_sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module ser_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // ser_sync2

// file: verilog/ser_event_latch.sv
// Sticky event register: set wins over clear, unused bits held at zero
`timescale 1ns/1ps
module ser_event_latch #(
   parameter int unsigned           WIDTH     = 8,
   parameter logic [WIDTH-1:0]      USED_MASK = '1,
   parameter logic [WIDTH-1:0]      RESET_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear_in,
   output logic      [WIDTH-1:0] evt_q,
   output logic      [WIDTH-1:0] evt_d
);

   // Per-bit latch; once set, later condition changes are ignored
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         if (USED_MASK[gi]) begin : g_used
            assign evt_d[gi] = (evt_q[gi] & ~clear_in) | set_in[gi];
         end else begin : g_unused
            assign evt_d[gi] = 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         evt_q <= RESET_VAL;
      end else begin
         evt_q <= evt_d;
      end
   end

endmodule // ser_event_latch

// file: verilog/ser_status_top.sv
// Status event reporting: event latches, enable masks and summary bits
//
// Behaviour
// - Event bits latch on their condition and hold until explicitly cleared.
// - Reading an event register, or clear-status, clears all its bits.
// - Instrument reset and device clear never touch event register bits.
// - Event registers are read-only; a read returns the set bits' weighted sum.
// - Each group's summary bit is the OR of enabled event bits.
// - Enable registers are writable and readable; reading leaves them unchanged.
// - Clear-status clears event bits but leaves every enable register alone.
// - Regulation bit 0 sets on voltage regulation loss, even momentary.
// - Regulation bit 1 sets on current regulation loss.
// - Regulation bit 4 sets on fan fault or over-temperature.
// - Regulation bit 9 sets on overvoltage trip, bit 10 on overcurrent trip.
// - Writing zero to the regulation enable clears it, blocking its summary.
// - Command event summary reaches status byte bit 5 through its mask.
// - Setting command event bits 2 to 5 also pushes an error queue entry.
// - Command event bit 0 sets when operation-complete finishes executing.
// - Command event bit 2 sets on any query fault condition.
// - Bit 3 flags device faults, bit 4 execution, bit 5 syntax faults.
// - Command event bit 7 sets after power has been cycled.
// - Event enable clears on zero write; at power-on only if setting is 1.
// - Status byte bit 3 carries masked regulation summary, bit 5 event summary.
// - Status byte summary bits follow the masked events without latching.
`timescale 1ns/1ps
module ser_status_top
   import ser_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // Analog side condition pins, asynchronous
   input  wire logic                  cc_mode_in,
   input  wire logic                  cv_mode_in,
   input  wire logic                  fan_fault_in,
   input  wire logic                  ovp_trip_in,
   input  wire logic                  ocp_trip_in,
   // Event pulses from the command engine, same clock
   input  wire logic                  operation_done_evt,
   input  wire logic                  empty_buffer_read_evt,
   input  wire logic                  unread_reply_evt,
   input  wire logic                  buffers_full_evt,
   input  wire logic                  selftest_fault_evt,
   input  wire logic                  calibration_fault_evt,
   input  wire logic                  execution_fault_evt,
   input  wire logic                  syntax_fault_evt,
   // Decoded commands, one-cycle strobes
   input  wire logic                  clear_status_cmd,
   input  wire logic                  event_read_cmd,
   input  wire logic                  regulation_event_read_cmd,
   input  wire logic                  event_enable_cmd,
   input  wire logic                  event_enable_read_cmd,
   input  wire logic                  regulation_enable_cmd,
   input  wire logic                  regulation_enable_read_cmd,
   input  wire logic [RD_W-1:0]       cmd_value,
   // Power-on behaviour of the event enable register
   input  wire logic                  power_on_clear_setting,
   input  wire logic [REG_W_STD-1:0]  saved_event_enable,
   // Query answers
   output logic      [RD_W-1:0]       rd_data_q,
   output logic                       rd_valid_q,
   // Summary bits toward the status byte
   output logic      [STB_W-1:0]      status_summary_q,
   output logic                       regulation_summary_bit,
   output logic                       event_summary_bit,
   // Error queue push request
   output logic                       err_push_q,
   output logic      [ERR_KIND_W-1:0] err_kind_q
);

   // =====================================================================
   // Condition input synchronisers
   // =====================================================================
   localparam int unsigned COND_W = 5;

   logic [COND_W-1:0] cond_raw;
   logic [COND_W-1:0] cond_sync;

   assign cond_raw = {ocp_trip_in, ovp_trip_in, fan_fault_in, cv_mode_in, cc_mode_in};

   ser_sync2 #(
      .WIDTH (COND_W)
   ) u_cond_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (cond_raw),
      .sync_out (cond_sync)
   );

   // =====================================================================
   // Regulation fault event register
   // =====================================================================
   logic [REG_W_REGULATION_SUMMARY_BIT-1:0] regulation_summary_bit_set;
   logic [REG_W_REGULATION_SUMMARY_BIT-1:0] regulation_fault_event_q;
   logic [REG_W_REGULATION_SUMMARY_BIT-1:0] regulation_fault_event_d;
   logic                  regulation_summary_bit_clear;

   always_comb begin
      regulation_summary_bit_set                = '0;
      // Levels sampled every cycle; a brief excursion still latches
      regulation_summary_bit_set[QB_VOLT_UNREG] = cond_sync[0];
      regulation_summary_bit_set[QB_CURR_UNREG] = cond_sync[1];
      regulation_summary_bit_set[QB_OVER_TEMP]  = cond_sync[2];
      regulation_summary_bit_set[QB_OVP_TRIP]   = cond_sync[3];
      regulation_summary_bit_set[QB_OCP_TRIP]   = cond_sync[4];
   end

   // Only a query or clear-status clears; no reset or device clear path
   assign regulation_summary_bit_clear = regulation_event_read_cmd | clear_status_cmd;

   ser_event_latch #(
      .WIDTH     (REG_W_REGULATION_SUMMARY_BIT),
      .USED_MASK (REGULATION_SUMMARY_BIT_USED_MASK),
      .RESET_VAL (REGULATION_SUMMARY_BIT_RESET)
   ) u_regulation_summary_bit_latch (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .set_in   (regulation_summary_bit_set),
      .clear_in (regulation_summary_bit_clear),
      .evt_q    (regulation_fault_event_q),
      .evt_d    (regulation_fault_event_d)
   );

   // =====================================================================
   // Power cycle detection
   // =====================================================================
   logic power_cycle_pend_q;

   // High for one cycle after reset release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         power_cycle_pend_q <= 1'b1;
      end else begin
         power_cycle_pend_q <= 1'b0;
      end
   end

   // =====================================================================
   // Command event flags register
   // =====================================================================
   logic [REG_W_STD-1:0] std_set;
   logic [REG_W_STD-1:0] command_event_flags_q;
   logic [REG_W_STD-1:0] command_event_flags_d;
   logic                 std_clear;
   logic                 operation_done_flag;
   logic                 query_fault_flag;
   logic                 device_fault_flag;
   logic                 execution_fault_flag;
   logic                 syntax_fault_flag;
   logic                 power_cycle_flag;

   assign operation_done_flag  = operation_done_evt;
   assign query_fault_flag     = empty_buffer_read_evt | unread_reply_evt
                                 | buffers_full_evt;
   assign device_fault_flag    = selftest_fault_evt | calibration_fault_evt;
   assign execution_fault_flag = execution_fault_evt;
   assign syntax_fault_flag    = syntax_fault_evt;
   assign power_cycle_flag     = power_cycle_pend_q;

   always_comb begin
      std_set                    = '0;
      std_set[SB_OPERATION_DONE] = operation_done_flag;
      std_set[SB_QUERY_FAULT]    = query_fault_flag;
      std_set[SB_DEVICE_FAULT]   = device_fault_flag;
      std_set[SB_EXECUTION]      = execution_fault_flag;
      std_set[SB_SYNTAX]         = syntax_fault_flag;
      std_set[SB_POWER_CYCLE]    = power_cycle_flag;
   end

   assign std_clear = event_read_cmd | clear_status_cmd;

   ser_event_latch #(
      .WIDTH     (REG_W_STD),
      .USED_MASK (STD_USED_MASK),
      .RESET_VAL (STD_RESET)
   ) u_std_latch (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .set_in   (std_set),
      .clear_in (std_clear),
      .evt_q    (command_event_flags_q),
      .evt_d    (command_event_flags_d)
   );

   // =====================================================================
   // Enable registers
   // =====================================================================
   logic [REG_W_REGULATION_SUMMARY_BIT-1:0] regulation_summary_bit_enable_q;
   logic [REG_W_STD-1:0]  event_enable_q;

   // Clear-status is deliberately absent here
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         regulation_summary_bit_enable_q <= REGULATION_SUMMARY_BIT_RESET;
      end else if (regulation_enable_cmd) begin
         regulation_summary_bit_enable_q <= cmd_value;
      end
   end

   // Power-on clear only when configured; otherwise restore saved mask
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         if (power_on_clear_setting) begin
            event_enable_q <= STD_RESET;
         end else begin
            event_enable_q <= saved_event_enable;
         end
      end else if (event_enable_cmd) begin
         event_enable_q <= cmd_value[REG_W_STD-1:0];
      end
   end

   // =====================================================================
   // Summary bits
   // =====================================================================
   logic regulation_summary_bit_sum_d;
   logic std_sum_d;

   // Built from next event values so the summary tracks the latch exactly
   assign regulation_summary_bit_sum_d = |(regulation_fault_event_d & regulation_summary_bit_enable_q);
   assign std_sum_d  = |(command_event_flags_d & event_enable_q);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status_summary_q       <= STB_RESET;
         regulation_summary_bit <= 1'b0;
         event_summary_bit      <= 1'b0;
      end else begin
         status_summary_q                     <= STB_RESET;
         status_summary_q[STB_REGULATION_SUM] <= regulation_summary_bit_sum_d;
         status_summary_q[STB_EVENT_SUM]      <= std_sum_d;
         regulation_summary_bit               <= regulation_summary_bit_sum_d;
         event_summary_bit                    <= std_sum_d;
      end
   end

   // =====================================================================
   // Query answers
   // =====================================================================
   ser_rd_src_t rd_src;

   // One query per cycle expected; fixed priority if several arrive
   always_comb begin
      if (event_read_cmd) begin
         rd_src = SER_RD_STD_EVT;
      end else if (regulation_event_read_cmd) begin
         rd_src = SER_RD_REGULATION_SUMMARY_BIT_EVT;
      end else if (event_enable_read_cmd) begin
         rd_src = SER_RD_STD_EN;
      end else if (regulation_enable_read_cmd) begin
         rd_src = SER_RD_REGULATION_SUMMARY_BIT_EN;
      end else begin
         rd_src = SER_RD_NONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_data_q  <= RD_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= (rd_src != SER_RD_NONE);
         unique case (rd_src)
            SER_RD_STD_EVT: begin
               rd_data_q <= {{(RD_W-REG_W_STD){1'b0}}, command_event_flags_q};
            end
            SER_RD_REGULATION_SUMMARY_BIT_EVT: begin
               rd_data_q <= regulation_fault_event_q;
            end
            SER_RD_STD_EN: begin
               rd_data_q <= {{(RD_W-REG_W_STD){1'b0}}, event_enable_q};
            end
            SER_RD_REGULATION_SUMMARY_BIT_EN: begin
               rd_data_q <= regulation_summary_bit_enable_q;
            end
            SER_RD_NONE: begin
               rd_data_q <= rd_data_q;
            end
         endcase
      end
   end

   // =====================================================================
   // Error queue push
   // =====================================================================
   logic [ERR_KIND_W-1:0] err_kind_d;

   assign err_kind_d = {syntax_fault_flag, execution_fault_flag,
                        device_fault_flag, query_fault_flag};

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         err_push_q <= 1'b0;
         err_kind_q <= '0;
      end else begin
         err_push_q <= |err_kind_d;
         err_kind_q <= err_kind_d;
      end
   end

endmodule // ser_status_top

// file: bench/ser_status_props.sv
// Concurrent checks on the status event reporting block ports
`timescale 1ns/1ps
module ser_status_props
   import ser_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  sys_rst,
   input wire logic                  operation_done_evt,
   input wire logic                  empty_buffer_read_evt,
   input wire logic                  unread_reply_evt,
   input wire logic                  buffers_full_evt,
   input wire logic                  selftest_fault_evt,
   input wire logic                  calibration_fault_evt,
   input wire logic                  execution_fault_evt,
   input wire logic                  syntax_fault_evt,
   input wire logic                  clear_status_cmd,
   input wire logic                  event_read_cmd,
   input wire logic                  regulation_event_read_cmd,
   input wire logic                  event_enable_cmd,
   input wire logic                  event_enable_read_cmd,
   input wire logic                  regulation_enable_cmd,
   input wire logic                  regulation_enable_read_cmd,
   input wire logic [RD_W-1:0]       cmd_value,
   input wire logic [RD_W-1:0]       rd_data_q,
   input wire logic                  rd_valid_q,
   input wire logic [STB_W-1:0]      status_summary_q,
   input wire logic                  regulation_summary_bit,
   input wire logic                  event_summary_bit,
   input wire logic                  err_push_q,
   input wire logic [ERR_KIND_W-1:0] err_kind_q
);
   logic any_rd;
   logic any_err;
   logic any_std;
   assign any_rd = event_read_cmd | regulation_event_read_cmd | event_enable_read_cmd
                 | regulation_enable_read_cmd;
   assign any_err = empty_buffer_read_evt | unread_reply_evt | buffers_full_evt
                  | selftest_fault_evt | calibration_fault_evt | execution_fault_evt
                  | syntax_fault_evt;
   assign any_std = any_err | operation_done_evt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   rd_answer_a: assert property (any_rd |=> rd_valid_q)
      else $error("read strobe without answer");
   rd_quiet_a: assert property (!any_rd |=> !rd_valid_q)
      else $error("answer without read strobe");
   std_unused_a: assert property (rd_valid_q && $past(event_read_cmd) |->
      rd_data_q[15:8] == 8'h00 && !rd_data_q[6] && !rd_data_q[1])
      else $error("unused command event bit read as one");
   read_clears_a: assert property ((event_read_cmd && !any_std) ##1
      (event_read_cmd && !any_std) |=> rd_data_q[7:0] == 8'h00)
      else $error("second read did not return cleared flags");
   sum_track_a: assert property (status_summary_q[3] == regulation_summary_bit &&
      status_summary_q[5] == event_summary_bit && (status_summary_q & 8'hD7) == 8'h00)
      else $error("status summary bits inconsistent");
   clear_drops_a: assert property (clear_status_cmd && !any_std |=> !event_summary_bit)
      else $error("event summary survived clear status");
   evt_hold_a: assert property (event_summary_bit && !clear_status_cmd &&
      !event_read_cmd && !event_enable_cmd |=> event_summary_bit)
      else $error("event summary dropped without clear");
   reg_hold_a: assert property (regulation_summary_bit && !clear_status_cmd &&
      !regulation_event_read_cmd && !regulation_enable_cmd |=> regulation_summary_bit)
      else $error("regulation summary dropped without clear");
   err_push_a: assert property (any_err |=> err_push_q)
      else $error("error event without queue push");
   err_quiet_a: assert property (!any_err |=> !err_push_q)
      else $error("queue push without error event");
   err_kind_a: assert property (err_push_q |-> err_kind_q == {$past(syntax_fault_evt),
      $past(execution_fault_evt), $past(selftest_fault_evt) | $past(calibration_fault_evt),
      $past(empty_buffer_read_evt) | $past(unread_reply_evt) | $past(buffers_full_evt)})
      else $error("error kind does not match events");
   en_rdbk_a: assert property (event_enable_cmd ##1 !event_enable_cmd ##1
      (event_enable_read_cmd && !event_read_cmd && !regulation_event_read_cmd)
      |=> rd_data_q[7:0] == $past(cmd_value[7:0], 3))
      else $error("event enable read back differs");
endmodule // ser_status_props

bind ser_status_top ser_status_props u_props (.core_clk, .sys_rst, .operation_done_evt,
   .empty_buffer_read_evt, .unread_reply_evt, .buffers_full_evt, .selftest_fault_evt,
   .calibration_fault_evt, .execution_fault_evt, .syntax_fault_evt, .clear_status_cmd,
   .event_read_cmd, .regulation_event_read_cmd, .event_enable_cmd, .event_enable_read_cmd,
   .regulation_enable_cmd, .regulation_enable_read_cmd, .cmd_value, .rd_data_q, .rd_valid_q,
   .status_summary_q, .regulation_summary_bit, .event_summary_bit, .err_push_q, .err_kind_q);

// file: bench/ser_ctrl_model.sv
// Remote controller model issuing decoded status commands
`timescale 1ns/1ps
module ser_ctrl_model
   import ser_pkg::*;
(
   input  wire logic       core_clk,
   output logic            clear_status_cmd,
   output logic            event_read_cmd,
   output logic            regulation_event_read_cmd,
   output logic            event_enable_cmd,
   output logic            event_enable_read_cmd,
   output logic            regulation_enable_cmd,
   output logic            regulation_enable_read_cmd,
   output logic [RD_W-1:0] cmd_value
);
   // Op: 0 clear, 1 event read, 2 regulation read, 3/4 event enable, 5/6 regulation enable
   logic [6:0] stb = 7'h00;
   assign clear_status_cmd = stb[0];
   assign event_read_cmd = stb[1];
   assign regulation_event_read_cmd = stb[2];
   assign event_enable_cmd = stb[3];
   assign event_enable_read_cmd = stb[4];
   assign regulation_enable_cmd = stb[5];
   assign regulation_enable_read_cmd = stb[6];
   initial cmd_value = 16'h0000;
   // Strobe held n cycles; data inverted once released
   task automatic issue(input int op, input logic [RD_W-1:0] val, input int n);
      @(posedge core_clk);
      #1 cmd_value = val;
      stb = 7'h01 << op;
      repeat (n) @(posedge core_clk);
      #1 stb = 7'h00;
      cmd_value = ~val;
   endtask
endmodule // ser_ctrl_model

// file: bench/ser_status_top_tb.sv
// Self-checking testbench for the status event reporting block
`timescale 1ns/1ps
module ser_status_top_tb
   import ser_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  sys_rst, power_on_clear_setting;
   logic [4:0]            pins;
   logic [7:0]            evts, saved_event_enable;
   logic                  clear_status_cmd, event_read_cmd, regulation_event_read_cmd;
   logic                  event_enable_cmd, event_enable_read_cmd;
   logic                  regulation_enable_cmd, regulation_enable_read_cmd;
   logic [RD_W-1:0]       cmd_value, rd_data_q, v;
   logic                  rd_valid_q, regulation_summary_bit, event_summary_bit, err_push_q;
   logic [STB_W-1:0]      status_summary_q;
   logic [ERR_KIND_W-1:0] err_kind_q;
   logic [15:0]           exp_q[$];
   int                    fail_count = 0;
   int                    checks = 0;
   int                    seed = 28032;
   int                    i;
   localparam logic [15:0] QW [5] = '{16'h0001, 16'h0002, 16'h0010, 16'h0200, 16'h0400};
   localparam logic [7:0]  EW [8] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20};
   localparam logic [3:0]  EK [8] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h8};
   always #20 core_clk = ~core_clk;
   ser_ctrl_model ctl (.core_clk, .clear_status_cmd, .event_read_cmd, .regulation_event_read_cmd,
      .event_enable_cmd, .event_enable_read_cmd, .regulation_enable_cmd,
      .regulation_enable_read_cmd, .cmd_value);
   ser_status_top dut (.core_clk, .sys_rst, .cc_mode_in(pins[0]), .cv_mode_in(pins[1]),
      .fan_fault_in(pins[2]), .ovp_trip_in(pins[3]), .ocp_trip_in(pins[4]),
      .operation_done_evt(evts[0]), .empty_buffer_read_evt(evts[1]),
      .unread_reply_evt(evts[2]), .buffers_full_evt(evts[3]), .selftest_fault_evt(evts[4]),
      .calibration_fault_evt(evts[5]), .execution_fault_evt(evts[6]),
      .syntax_fault_evt(evts[7]), .clear_status_cmd, .event_read_cmd,
      .regulation_event_read_cmd, .event_enable_cmd, .event_enable_read_cmd,
      .regulation_enable_cmd, .regulation_enable_read_cmd, .cmd_value, .power_on_clear_setting,
      .saved_event_enable, .rd_data_q, .rd_valid_q, .status_summary_q, .regulation_summary_bit,
      .event_summary_bit, .err_push_q, .err_kind_q);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic pocs, input logic [7:0] saved);
      @(posedge core_clk);
      #1 sys_rst = 1'b1;
      power_on_clear_setting = pocs;
      saved_event_enable = saved;
      repeat (6) @(posedge core_clk);
      #1 sys_rst = 1'b0;
   endtask
   task automatic rd(input int op, input logic [15:0] exp, input int n);
      repeat (n) exp_q.push_back(exp);
      ctl.issue(op, 16'h0000, n);
   endtask
   task automatic pulse_pin(input logic [4:0] m);
      @(posedge core_clk);
      #1 pins = m;
      repeat (2) @(posedge core_clk);
      #1 pins = 5'h00;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic pulse_evt(input int k);
      @(posedge core_clk);
      #1 evts = 8'h01 << k;
      @(posedge core_clk);
      #1 evts = 8'h00;
      check(16'(err_push_q), 16'(k != 0));
      if (k != 0) begin
         check(16'(err_kind_q), 16'(EK[k]));
      end
   endtask
   // Answer monitor: oldest expectation per cycle with rd_valid_q high
   always @(posedge core_clk) begin
      if (rd_valid_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(16'(rd_valid_q), 16'h0000);
         end else begin
            check(rd_data_q, exp_q.pop_front());
         end
      end
   end
   initial begin
      sys_rst = 1'b1;
      pins = 5'h00;
      evts = 8'h00;
      power_on_clear_setting = 1'b1;
      saved_event_enable = 8'h00;
      do_reset(1'b1, 8'hA5);
      rd(1, 16'h0080, 1);
      rd(1, 16'h0000, 2);
      for (i = 0; i < 5; i++) begin
         pulse_pin(5'h01 << i);
         rd(2, QW[i], 1);
      end
      pulse_pin(5'h1F);
      rd(2, 16'h0613, 1);
      for (i = 0; i < 8; i++) begin
         pulse_evt(i);
         rd(1, {8'h00, EW[i]}, 1);
      end
      v = 16'($random(seed)) | 16'h0200;
      ctl.issue(5, v, 1);
      rd(6, v, 2);
      ctl.issue(3, 16'h0020, 1);
      rd(4, 16'h0020, 1);
      pulse_pin(5'h08);
      check(16'(status_summary_q), 16'h0008);
      pulse_evt(7);
      @(posedge core_clk);
      check(16'(status_summary_q), 16'h0028);
      check(16'({regulation_summary_bit, event_summary_bit}), 16'h0003);
      ctl.issue(0, 16'h0000, 1);
      check(16'(status_summary_q), 16'h0000);
      rd(4, 16'h0020, 1);
      rd(6, v, 1);
      rd(2, 16'h0000, 1);
      ctl.issue(5, 16'h0000, 1);
      pulse_pin(5'h08);
      check(16'(regulation_summary_bit), 16'h0000);
      rd(2, 16'h0200, 1);
      exp_q.push_back(16'h0000);
      fork
         pulse_evt(7);
         ctl.issue(1, 16'h0000, 1);
      join
      rd(1, 16'h0020, 1);
      ctl.issue(3, 16'h0000, 1);
      rd(4, 16'h0000, 1);
      v = 16'($random(seed));
      do_reset(1'b0, v[7:0]);
      rd(4, {8'h00, v[7:0]}, 1);
      do_reset(1'b1, v[7:0]);
      rd(4, 16'h0000, 1);
      rd(1, 16'h0080, 1);
      for (i = 0; i < 20 && exp_q.size() != 0; i++) begin
         @(posedge core_clk);
      end
      if (exp_q.size() != 0) begin
         fail_count++;
      end
      final_report();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      final_report();
   end
endmodule // ser_status_top_tb
